// ==== hdl/sfa_map.svh ====
`ifndef SFA_MAP_SVH
`define SFA_MAP_SVH
`define SFA_CARRY_POS 0
`define SFA_PARITY_POS 2
`define SFA_AUX_POS 4
`define SFA_ZERO_POS 6
`define SFA_SIGN_POS 7
`define SFA_TRAP_POS 8
`define SFA_INTEN_POS 9
`define SFA_DIR_POS 10
`define SFA_OVF_POS 11
`define SFA_FLAGS_RESET 16'h0002
`define SFA_FLAGS_FIXED_MASK 16'hF02A
`define SFA_FLAGS_FIXED_VAL 16'h0002
`define SFA_STEP_VECTOR 8'h01
`endif

// ==== hdl/sfa_pkg.sv ====
package sfa_pkg;
  typedef enum logic [2:0] {
    SFA_OP_ADD, SFA_OP_ADC, SFA_OP_SUB, SFA_OP_SBB,
    SFA_OP_AND, SFA_OP_OR, SFA_OP_XOR, SFA_OP_PASS
  } sfa_op_e;
  typedef enum logic [1:0] {
    SFA_SEG_EXTRA, SFA_SEG_CODE, SFA_SEG_STACK, SFA_SEG_DATA
  } sfa_seg_e;
  typedef enum logic [1:0] {
    SFA_REF_FETCH, SFA_REF_STACK, SFA_REF_DATA, SFA_REF_STR_DST
  } sfa_ref_e;
  typedef enum logic [1:0] {
    SFA_DISP_NONE, SFA_DISP_8, SFA_DISP_16
  } sfa_disp_e;
endpackage

// ==== hdl/sfa_alu.sv ====
`timescale 1ns/10ps
`include "sfa_map.svh"
module sfa_alu (
  input wire sfa_pkg::sfa_op_e op,
  input wire logic word_op,
  input wire logic carry_in,
  input wire logic [15:0] src_a,
  input wire logic [15:0] src_b,
  output logic [15:0] result,
  output logic carry_out,
  output logic aux_out,
  output logic ovf_out,
  output logic arith
);
  import sfa_pkg::*;
  logic [16:0] sum;
  logic [15:0] b_eff;
  logic sub;
  logic msb_a, msb_b, msb_r;
  always_comb begin
    sub = (op == SFA_OP_SUB) || (op == SFA_OP_SBB);
    arith = (op == SFA_OP_ADD) || (op == SFA_OP_ADC) || sub;
    b_eff = sub ? ~src_b : src_b;
    sum = 17'h0_0000;
    unique case (op)
      SFA_OP_ADD: sum = {1'b0, src_a} + {1'b0, b_eff};
      SFA_OP_ADC: sum = {1'b0, src_a} + {1'b0, b_eff} + {16'h0000, carry_in};
      SFA_OP_SUB: sum = {1'b0, src_a} + {1'b0, b_eff} + 17'h0_0001;
      SFA_OP_SBB: sum = {1'b0, src_a} + {1'b0, b_eff} + {16'h0000, ~carry_in};
      SFA_OP_AND: sum = {1'b0, src_a & src_b};
      SFA_OP_OR: sum = {1'b0, src_a | src_b};
      SFA_OP_XOR: sum = {1'b0, src_a ^ src_b};
      SFA_OP_PASS: sum = {1'b0, src_b};
    endcase
    // full sum kept: the byte carry is the carry into bit 8
    result = word_op ? sum[15:0] : {8'h00, sum[7:0]};
    // carry at the width of the operand
    if (word_op) begin
      carry_out = arith ? (sum[16] ^ sub) : 1'b0;
      msb_a = src_a[15];
      msb_b = b_eff[15];
      msb_r = sum[15];
    end else begin
      carry_out = arith ? ((src_a[8] ^ b_eff[8] ^ sum[8]) ^ sub) : 1'b0;
      msb_a = src_a[7];
      msb_b = b_eff[7];
      msb_r = sum[7];
    end
    aux_out = arith ? ((src_a[4] ^ b_eff[4] ^ sum[4]) ^ sub) : 1'b0;
    ovf_out = arith ? ((msb_a == msb_b) && (msb_r != msb_a)) : 1'b0;
  end
endmodule

// ==== hdl/sfa_addr.sv ====
`timescale 1ns/10ps
module sfa_addr (
  input wire sfa_pkg::sfa_ref_e ref_kind,
  input wire logic base_is_ptr,
  input wire logic override_en,
  input wire sfa_pkg::sfa_seg_e override_seg,
  input wire sfa_pkg::sfa_disp_e disp_kind,
  input wire logic [15:0] disp,
  input wire logic use_base,
  input wire logic use_index,
  input wire logic index_is_dest,
  input wire logic [15:0] base_reg_b,
  input wire logic [15:0] base_pointer_reg,
  input wire logic [15:0] src_index_reg,
  input wire logic [15:0] dest_index_reg,
  input wire logic [15:0] ip_offset,
  output sfa_pkg::sfa_seg_e seg_sel,
  output logic [15:0] offset
);
  import sfa_pkg::*;
  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction
  logic [15:0] d, b, x;
  always_comb begin
    unique case (ref_kind)
      SFA_REF_FETCH: seg_sel = SFA_SEG_CODE;
      SFA_REF_STACK: seg_sel = SFA_SEG_STACK;
      SFA_REF_STR_DST: seg_sel = SFA_SEG_EXTRA;
      SFA_REF_DATA: seg_sel = SFA_SEG_DATA;
    endcase
    if (ref_kind == SFA_REF_DATA && use_base && base_is_ptr) begin
      seg_sel = SFA_SEG_STACK;
    end
    // fetch and string destination cannot be overridden
    if (override_en && (ref_kind == SFA_REF_DATA ||
        ref_kind == SFA_REF_STACK && disp_kind != SFA_DISP_NONE)) begin
      seg_sel = override_seg;
    end
    unique case (disp_kind)
      SFA_DISP_8: d = sext8(disp[7:0]);
      SFA_DISP_16: d = disp;
      default: d = 16'h0000;
    endcase
    b = base_is_ptr ? base_pointer_reg : base_reg_b;
    if (!use_base) begin
      b = 16'h0000;
    end
    x = index_is_dest ? dest_index_reg : src_index_reg;
    if (!use_index) begin
      x = 16'h0000;
    end
    // carry out of the sum is dropped by the 16-bit target
    if (ref_kind == SFA_REF_FETCH) begin
      offset = ip_offset;
    end else begin
      offset = 16'(d + b + x);
    end
  end
endmodule

// ==== hdl/sfa_core.sv ====
`timescale 1ns/10ps
`include "sfa_map.svh"
module sfa_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic exec_valid,
  input wire sfa_pkg::sfa_op_e op,
  input wire logic word_op,
  input wire logic use_imm,
  input wire logic [15:0] reg_operand_a,
  input wire logic [15:0] reg_operand_b,
  input wire logic [15:0] imm_operand,
  input wire logic [15:0] flag_mask,
  input wire logic instr_done,
  input wire logic flags_load,
  input wire logic [15:0] flags_load_value,
  input wire logic int_taken,
  input wire logic maskable_req,
  input wire logic string_step,
  input wire logic [15:0] string_index_in,
  input wire logic mem_valid,
  input wire sfa_pkg::sfa_ref_e ref_kind,
  input wire logic base_is_ptr,
  input wire logic override_en,
  input wire sfa_pkg::sfa_seg_e override_seg,
  input wire sfa_pkg::sfa_disp_e disp_kind,
  input wire logic [15:0] disp,
  input wire logic use_base,
  input wire logic use_index,
  input wire logic index_is_dest,
  input wire logic [15:0] base_reg_b,
  input wire logic [15:0] base_pointer_reg,
  input wire logic [15:0] src_index_reg,
  input wire logic [15:0] dest_index_reg,
  input wire logic [15:0] ip_offset,
  input wire logic [15:0] code_segment_reg,
  input wire logic [15:0] stack_segment_reg,
  input wire logic [15:0] data_segment_reg,
  input wire logic [15:0] extra_segment_reg,
  output logic [15:0] status_flags_word,
  output logic [15:0] result,
  output logic step_int,
  output logic [7:0] step_vector,
  output logic maskable_accept,
  output logic [15:0] string_index_out,
  output logic [15:0] addr_segment,
  output logic [15:0] addr_offset,
  output logic addr_valid
);
  import sfa_pkg::*;
  function automatic logic even_ones(input logic [7:0] v);
    return ~(^v);
  endfunction
  logic [15:0] flags;
  logic [15:0] next_flags;
  logic [15:0] opnd_b;
  logic [15:0] alu_res;
  logic alu_c, alu_a, alu_o, alu_arith;
  logic step_armed;
  logic res_msb;
  sfa_seg_e seg_sel;
  logic [15:0] off_comb;
  logic [15:0] seg_val;
  logic [15:0] str_step;
  // immediate operand replaces second register operand
  assign opnd_b = use_imm ? imm_operand : reg_operand_b;
  sfa_alu u_alu (
    .op(op),
    .word_op(word_op),
    .carry_in(flags[`SFA_CARRY_POS]),
    .src_a(reg_operand_a),
    .src_b(opnd_b),
    .result(alu_res),
    .carry_out(alu_c),
    .aux_out(alu_a),
    .ovf_out(alu_o),
    .arith(alu_arith)
  );
  sfa_addr u_addr (
    .ref_kind(ref_kind),
    .base_is_ptr(base_is_ptr),
    .override_en(override_en),
    .override_seg(override_seg),
    .disp_kind(disp_kind),
    .disp(disp),
    .use_base(use_base),
    .use_index(use_index),
    .index_is_dest(index_is_dest),
    .base_reg_b(base_reg_b),
    .base_pointer_reg(base_pointer_reg),
    .src_index_reg(src_index_reg),
    .dest_index_reg(dest_index_reg),
    .ip_offset(ip_offset),
    .seg_sel(seg_sel),
    .offset(off_comb)
  );
  assign res_msb = word_op ? alu_res[15] : alu_res[7];
  always_comb begin
    next_flags = flags;
    if (flags_load) begin
      next_flags = flags_load_value;
    end
    if (exec_valid) begin
      // only bits named in flag_mask are updated
      if (flag_mask[`SFA_CARRY_POS]) begin
        next_flags[`SFA_CARRY_POS] = alu_c;
      end
      if (flag_mask[`SFA_PARITY_POS]) begin
        next_flags[`SFA_PARITY_POS] = even_ones(alu_res[7:0]);
      end
      if (flag_mask[`SFA_AUX_POS]) begin
        next_flags[`SFA_AUX_POS] = alu_a;
      end
      if (flag_mask[`SFA_ZERO_POS]) begin
        next_flags[`SFA_ZERO_POS] = (alu_res == 16'h0000);
      end
      if (flag_mask[`SFA_SIGN_POS]) begin
        next_flags[`SFA_SIGN_POS] = res_msb;
      end
      if (flag_mask[`SFA_OVF_POS]) begin
        next_flags[`SFA_OVF_POS] = alu_o;
      end
    end
    if (step_int) begin
      next_flags[`SFA_TRAP_POS] = 1'b0;
    end
    if (int_taken || step_int) begin
      next_flags[`SFA_INTEN_POS] = 1'b0;
    end
    next_flags = (next_flags & ~`SFA_FLAGS_FIXED_MASK) |
      `SFA_FLAGS_FIXED_VAL;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `SFA_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
  assign status_flags_word = flags;
  // trap is armed by the instruction that sees it set, fires after the next
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step_armed <= 1'b0;
      step_int <= 1'b0;
    end else begin
      step_int <= 1'b0;
      if (instr_done && !step_int) begin
        if (step_armed && flags[`SFA_TRAP_POS]) begin
          step_int <= 1'b1;
          step_armed <= 1'b0;
        end else begin
          step_armed <= flags[`SFA_TRAP_POS];
        end
      end
    end
  end
  assign step_vector = `SFA_STEP_VECTOR;
  assign maskable_accept = maskable_req && flags[`SFA_INTEN_POS];
  assign str_step = word_op ? 16'h0002 : 16'h0001;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result <= 16'h0000;
      string_index_out <= 16'h0000;
    end else begin
      if (exec_valid) begin
        result <= alu_res;
      end
      if (string_step) begin
        if (flags[`SFA_DIR_POS]) begin
          string_index_out <= string_index_in - str_step;
        end else begin
          string_index_out <= string_index_in + str_step;
        end
      end
    end
  end
  always_comb begin
    unique case (seg_sel)
      SFA_SEG_CODE: seg_val = code_segment_reg;
      SFA_SEG_STACK: seg_val = stack_segment_reg;
      SFA_SEG_DATA: seg_val = data_segment_reg;
      SFA_SEG_EXTRA: seg_val = extra_segment_reg;
    endcase
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_segment <= 16'h0000;
      addr_offset <= 16'h0000;
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= mem_valid;
      if (mem_valid) begin
        addr_segment <= seg_val;
        addr_offset <= off_comb;
      end
    end
  end
  property p_step_clears;
    @(posedge clock) disable iff (!arst_n)
      step_int |=> !flags[`SFA_TRAP_POS];
  endproperty
  a_step_clears: assert property (p_step_clears)
    else $error("trap bit not cleared by step interrupt");
  property p_int_gate;
    @(posedge clock) disable iff (!arst_n)
      maskable_accept |-> flags[`SFA_INTEN_POS];
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("maskable interrupt accepted while disabled");
  property p_zero;
    @(posedge clock) disable iff (!arst_n)
      exec_valid && flag_mask[`SFA_ZERO_POS] && !step_int && !flags_load
      |=> flags[`SFA_ZERO_POS] == ($past(alu_res) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag mismatch");
  property p_parity;
    @(posedge clock) disable iff (!arst_n)
      exec_valid && flag_mask[`SFA_PARITY_POS]
      |=> flags[`SFA_PARITY_POS] == ~(^result[7:0]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag mismatch");
  property p_sign;
    @(posedge clock) disable iff (!arst_n)
      exec_valid && flag_mask[`SFA_SIGN_POS]
      |=> flags[`SFA_SIGN_POS] == ($past(word_op) ? result[15] : result[7]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag mismatch");
  property p_hold;
    @(posedge clock) disable iff (!arst_n)
      !exec_valid && !flags_load && !step_int && !int_taken
      |=> $stable(flags);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags changed without cause");
  property p_fixed;
    @(posedge clock) disable iff (!arst_n)
      (flags & `SFA_FLAGS_FIXED_MASK) == `SFA_FLAGS_FIXED_VAL;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("undefined flag positions not constant");
  property p_fetch_cs;
    @(posedge clock) disable iff (!arst_n)
      mem_valid && ref_kind == SFA_REF_FETCH
      |=> addr_segment == $past(code_segment_reg);
  endproperty
  a_fetch_cs: assert property (p_fetch_cs)
    else $error("prefetch not in code segment");
  property p_dir;
    @(posedge clock) disable iff (!arst_n)
      string_step && flags[`SFA_DIR_POS] && !word_op
      |=> string_index_out == 16'($past(string_index_in) - 16'h0001);
  endproperty
  a_dir: assert property (p_dir)
    else $error("string index not decremented");
  property p_int_clear;
    @(posedge clock) disable iff (!arst_n)
      int_taken |=> !flags[`SFA_INTEN_POS];
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt enable not cleared by interrupt");
  property p_step_pulse;
    @(posedge clock) disable iff (!arst_n)
      step_int |=> !step_int;
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("step interrupt longer than one cycle");
  property p_addr_valid;
    @(posedge clock) disable iff (!arst_n)
      mem_valid |=> addr_valid;
  endproperty
  a_addr_valid: assert property (p_addr_valid)
    else $error("address not marked valid after capture");
  property p_load;
    @(posedge clock) disable iff (!arst_n)
      flags_load && !exec_valid && !step_int && !int_taken
      |=> flags == (($past(flags_load_value) & ~`SFA_FLAGS_FIXED_MASK) |
        `SFA_FLAGS_FIXED_VAL);
  endproperty
  a_load: assert property (p_load)
    else $error("flag word load mismatch");
endmodule

// ==== verification/test_status_flags_and_operand_address.sv ====
`timescale 1ns/10ps
module test_status_flags_and_operand_address;
  import sfa_pkg::*;
  localparam sfa_ref_e R_FET = SFA_REF_FETCH;
  localparam sfa_ref_e R_STK = SFA_REF_STACK;
  localparam sfa_ref_e R_DAT = SFA_REF_DATA;
  localparam sfa_ref_e R_DST = SFA_REF_STR_DST;
  localparam sfa_seg_e S_EXT = SFA_SEG_EXTRA;
  localparam sfa_seg_e S_COD = SFA_SEG_CODE;
  localparam sfa_seg_e S_STK = SFA_SEG_STACK;
  localparam sfa_seg_e S_DAT = SFA_SEG_DATA;
  localparam sfa_disp_e D_0 = SFA_DISP_NONE;
  localparam sfa_disp_e D_8 = SFA_DISP_8;
  localparam sfa_disp_e D_16 = SFA_DISP_16;
  logic clock = 1'b0, arst_n = 1'b0, exec_valid = 1'b0, word_op = 1'b0;
  logic use_imm = 1'b0, instr_done = 1'b0, flags_load = 1'b0;
  logic int_taken = 1'b0, maskable_req = 1'b0, string_step = 1'b0;
  logic mem_valid = 1'b0, base_is_ptr = 1'b0, override_en = 1'b0;
  logic use_base = 1'b0, use_index = 1'b0, index_is_dest = 1'b0;
  sfa_op_e op = SFA_OP_ADD;
  sfa_ref_e ref_kind = SFA_REF_FETCH;
  sfa_seg_e override_seg = SFA_SEG_EXTRA;
  sfa_disp_e disp_kind = SFA_DISP_NONE;
  logic [15:0] reg_operand_a = '0, reg_operand_b = '0, imm_operand = '0;
  logic [15:0] flag_mask = '0, flags_load_value = '0, string_index_in = '0;
  logic [15:0] disp = '0, base_reg_b = '0, base_pointer_reg = '0;
  logic [15:0] src_index_reg = '0, dest_index_reg = '0, ip_offset = '0;
  logic [15:0] code_segment_reg = '0, stack_segment_reg = '0;
  logic [15:0] data_segment_reg = '0, extra_segment_reg = '0;
  logic [15:0] status_flags_word, result, string_index_out;
  logic [15:0] addr_segment, addr_offset;
  logic [7:0] step_vector;
  logic step_int, maskable_accept, addr_valid;
  logic [15:0] fl_exp = 16'h0002, kk = 16'h0000;
  logic [15:0] ta [4] = '{16'hFFFF, 16'h7FFF, 16'h8000, 16'h00F8};
  logic [15:0] tb [4] = '{16'h0001, 16'h0001, 16'hFFFF, 16'h0008};
  int miscompares = 0, num_checks = 0, cycles = 0;

  sfa_core u_dut (.clock, .arst_n, .exec_valid, .op, .word_op, .use_imm,
    .reg_operand_a, .reg_operand_b, .imm_operand, .flag_mask, .instr_done,
    .flags_load, .flags_load_value, .int_taken, .maskable_req, .string_step,
    .string_index_in, .mem_valid, .ref_kind, .base_is_ptr, .override_en,
    .override_seg, .disp_kind, .disp, .use_base, .use_index, .index_is_dest,
    .base_reg_b, .base_pointer_reg, .src_index_reg, .dest_index_reg,
    .ip_offset, .code_segment_reg, .stack_segment_reg, .data_segment_reg,
    .extra_segment_reg, .status_flags_word, .result, .step_int, .step_vector,
    .maskable_accept, .string_index_out, .addr_segment, .addr_offset,
    .addr_valid);

  always #50 clock = ~clock;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // reference flag update: only bits enabled by the mask may move
  function automatic logic [15:0] exp_alu(input int o, input logic w,
      input logic [15:0] a, b, f, m, output logic [15:0] r);
    logic [16:0] s;
    logic [15:0] u;
    logic cin;
    int n;
    n = w ? 15 : 7;
    cin = (o == 1 || o == 3) ? f[0] : 1'b0;
    case (o)
      0, 1: s = {1'b0, a} + {1'b0, b} + 17'(cin);
      2, 3: s = {1'b0, a} - {1'b0, b} - 17'(cin);
      4: s = {1'b0, a & b};
      5: s = {1'b0, a | b};
      7: s = {1'b0, b};
      default: s = {1'b0, a ^ b};
    endcase
    r = w ? s[15:0] : {8'h00, s[7:0]};
    u = 16'h0000;
    u[0] = (o < 4) ? s[n + 1] : 1'b0;
    u[2] = ~^r[7:0];
    u[4] = (o < 4) ? (a[4] ^ b[4] ^ s[4]) : 1'b0;
    u[6] = (r == 16'h0000);
    u[7] = r[n];
    if (o < 2) begin
      u[11] = (a[n] == b[n]) && (r[n] != a[n]);
    end else if (o < 4) begin
      u[11] = (a[n] != b[n]) && (r[n] != a[n]);
    end
    return (f & ~m) | (u & m);
  endfunction

  task automatic alu(input int o, input logic w, input logic [15:0] a, b, m);
    logic [15:0] r;
    logic ui;
    fl_exp = exp_alu(o, w, a, b, fl_exp, m, r);
    ui = ~use_imm;
    @(posedge clock);
    exec_valid <= 1'b1;
    op <= sfa_op_e'(o[2:0]);
    word_op <= w;
    use_imm <= ui;
    reg_operand_a <= a;
    imm_operand <= ui ? b : ~b;
    reg_operand_b <= ui ? ~b : b;
    flag_mask <= m;
    @(posedge clock);
    exec_valid <= 1'b0;
    #1;
    chk(result, r);
    chk(status_flags_word, fl_exp);
  endtask

  task automatic load(input logic [15:0] v);
    @(posedge clock);
    flags_load <= 1'b1;
    flags_load_value <= v;
    @(posedge clock);
    flags_load <= 1'b0;
    #1;
    fl_exp = (v & 16'h0FD5) | 16'h0002;
    chk(status_flags_word, fl_exp);
  endtask

  task automatic pulse_done();
    @(posedge clock);
    instr_done <= 1'b1;
    @(posedge clock);
    instr_done <= 1'b0;
    #1;
  endtask

  task automatic str(input logic d, w, input logic [15:0] v, e);
    load({5'h00, d, 10'h000});
    @(posedge clock);
    string_step <= 1'b1;
    string_index_in <= v;
    word_op <= w;
    @(posedge clock);
    string_step <= 1'b0;
    #1;
    chk(string_index_out, e);
  endtask

  // bo = {base is pointer, override}, bi = {use base, use index, dest index}
  task automatic ad(input sfa_ref_e rk, input logic [1:0] bo,
      input sfa_seg_e os,
      input sfa_disp_e dk, input logic [15:0] dv, input logic [2:0] bi,
      input sfa_seg_e es);
    logic [15:0] off;
    kk = kk + 16'h0001;
    off = (dk == D_16) ? dv : 16'h0000;
    if (dk == D_8) begin
      off = {{8{dv[7]}}, dv[7:0]};
    end
    if (bi[2]) begin
      off = off + (bo[1] ? 16'h8000 + kk : 16'h1230 + kk);
    end
    if (bi[1]) begin
      off = off + (bi[0] ? 16'hFFF0 + kk : 16'h0F00 + kk);
    end
    if (rk == R_FET) begin
      off = 16'hA000 + kk;
    end
    @(posedge clock);
    mem_valid <= 1'b1;
    ref_kind <= rk;
    {base_is_ptr, override_en} <= bo;
    override_seg <= os;
    disp_kind <= dk;
    disp <= dv;
    {use_base, use_index, index_is_dest} <= bi;
    base_reg_b <= 16'h1230 + kk;
    base_pointer_reg <= 16'h8000 + kk;
    src_index_reg <= 16'h0F00 + kk;
    dest_index_reg <= 16'hFFF0 + kk;
    ip_offset <= 16'hA000 + kk;
    extra_segment_reg <= {S_EXT, 14'h0000} ^ kk;
    code_segment_reg <= {S_COD, 14'h0000} ^ kk;
    stack_segment_reg <= {S_STK, 14'h0000} ^ kk;
    data_segment_reg <= {S_DAT, 14'h0000} ^ kk;
    @(posedge clock);
    mem_valid <= 1'b0;
    #1;
    chk(16'(addr_valid), 16'h0001);
    chk(addr_segment, {es, 14'h0000} ^ kk);
    chk(addr_offset, off);
  endtask

  initial begin
    logic [15:0] av, bv;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk(status_flags_word, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 8; j++) begin
        av = (j < 4) ? ta[j] : ta[j - 4] & 16'h00FF;
        bv = (j < 4) ? tb[j] : tb[j - 4] & 16'h00FF;
        alu(i, j < 4, av, bv, (i < 4) ? 16'h08D5 : 16'h08C5);
      end
    end
    alu(0, 1'b1, 16'h1234, 16'h4321, 16'h0000);
    load(16'hFFFF);
    @(posedge clock);
    maskable_req <= 1'b1;
    @(posedge clock);
    #1;
    chk(16'(maskable_accept), 16'h0001);
    @(posedge clock);
    int_taken <= 1'b1;
    @(posedge clock);
    int_taken <= 1'b0;
    #1;
    fl_exp[9] = 1'b0;
    chk(status_flags_word, fl_exp);
    chk(16'(maskable_accept), 16'h0000);
    load(16'h0300);
    pulse_done();
    chk(16'(step_int), 16'h0000);
    pulse_done();
    chk(16'(step_int), 16'h0001);
    chk({8'h00, step_vector}, 16'h0001);
    @(posedge clock);
    #1;
    chk(16'(step_int), 16'h0000);
    chk(status_flags_word, 16'h0002);
    str(1'b0, 1'b0, 16'hFFFF, 16'h0000);
    str(1'b1, 1'b0, 16'h0000, 16'hFFFF);
    str(1'b0, 1'b1, 16'hFFFF, 16'h0001);
    str(1'b1, 1'b1, 16'h0001, 16'hFFFF);
    ad(R_FET, 2'b01, S_DAT, D_16, 16'h0100, 3'b110, S_COD);
    ad(R_STK, 2'b00, S_EXT, D_0, 16'h0000, 3'b000, S_STK);
    ad(R_DAT, 2'b10, S_EXT, D_8, 16'h5580, 3'b111, S_STK);
    ad(R_DAT, 2'b00, S_COD, D_16, 16'hF000, 3'b110, S_DAT);
    ad(R_DST, 2'b01, S_COD, D_0, 16'h0000, 3'b011, S_EXT);
    ad(R_DAT, 2'b01, S_EXT, D_8, 16'h007F, 3'b000, S_EXT);
    ad(R_DAT, 2'b11, S_DAT, D_0, 16'h0000, 3'b100, S_DAT);
    ad(R_DAT, 2'b00, S_STK, D_0, 16'h0000, 3'b010, S_DAT);
    ad(R_STK, 2'b01, S_DAT, D_8, 16'h0004, 3'b000, S_DAT);
    ad(R_STK, 2'b01, S_DAT, D_0, 16'h0000, 3'b000, S_STK);
    report_and_stop();
  end
endmodule
